// *** logic/pil_pkg.sv ***
// Constants and carriers for the protection interrupt logic.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package pil_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ    = 100;
    localparam int T_DEB_US   = 20;
    localparam int T_SC_US    = 1000;
    localparam int DEB_CYC    = T_DEB_US * CLK_MHZ;
    localparam int SC_CYC_DEF = T_SC_US * CLK_MHZ;
    localparam int CNT_W      = 17;
    localparam int NCORE      = 4;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_TOP_FLAG  = 12'h000;
    localparam logic [11:0] OFF_TOP_MASK  = 12'h004;
    localparam logic [11:0] OFF_TOP_STAT  = 12'h008;
    localparam logic [11:0] OFF_FLAG01    = 12'h00c;
    localparam logic [11:0] OFF_FLAG23    = 12'h010;
    localparam logic [11:0] OFF_CORE_MASK = 12'h014;
    localparam logic [11:0] OFF_CORE_STAT = 12'h018;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    // Top register: bits 3:0 hold the per-core summary
    localparam int TOP_TW  = 4;
    localparam int TOP_TSD = 5;
    localparam int TOP_LD  = 6;
    localparam int TOP_RST = 7;
    // Core nibble: one nibble per core
    localparam int CB_ILIM = 0;
    localparam int CB_SC   = 1;
    localparam int CB_PG   = 2;
    localparam int CB_RUN  = 3;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [3:0] CORE_MASK_RST = 4'h0;
    localparam logic       TOP_MASK_RST  = 1'b0;

    // Raw analog comparator outputs, asynchronous to clk_sys
    typedef struct packed {
        logic [3:0] ilim;
        logic [3:0] fbLow;
        logic [3:0] pg;
        logic       tWarn;
        logic       tSd;
    } pil_ana_t;
endpackage

// *** logic/pil_debounce.sv ***
// Symmetric debounce filter for one synchronised level.
// Assumes rawIn is already in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module pil_debounce #(
    parameter int LEN = 2
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // Level in and filtered level out
    input  wire logic rawIn,
    output logic      levelOut
);
    localparam int W = pil_pkg::CNT_W;
    localparam logic [W-1:0] LAST = W'(LEN - 1);

    logic [W-1:0] cntReg;
    logic         levelReg;

    // Output flips only after LEN cycles of steady disagreement
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cntReg   <= '0;
            levelReg <= 1'b0;
        end else if (rawIn == levelReg) begin
            cntReg <= '0;
        end else if (cntReg == LAST) begin
            cntReg   <= '0;
            levelReg <= rawIn;
        end else begin
            cntReg <= cntReg + 1'b1;
        end
    end

    assign levelOut = levelReg;
endmodule
`default_nettype wire

// *** logic/pil_protect_irq.sv ***
// Protection and interrupt logic for a four-core step-down regulator.
// Assumes a 100 MHz clk_sys, an APB master and raw comparator levels.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: Sort events into warnings, core-disabling protections and faults.
// RULE2: Any warning or protection sets its flag and pulls irq low.
// RULE3: Irq stays low while any unmasked flag is pending.
// RULE4: After a shutdown fault, reset_occurred_flag is set at start-up.
// RULE5: Peak current regulation held 20 us sets current_limit_flag.
// RULE6: Current limit flag write-1 clear is ignored while condition active.
// RULE7: Live per-core current_limit_status bit is readable.
// RULE8: Startup or overload under 0.35 V for 1 ms disables core, flags.
// RULE9: Core disabled by protection shows core_running_status zero.
// RULE10: Host clears short_circuit_flag by writing 1 in its pair register.
// RULE11: Thermal warning flag is maskable, live status, clear blocked if hot.
// RULE12: Thermal shutdown stops all cores, unmaskable, clear blocked if hot.
// RULE13: Software, supply glitch or reset pin rise reset regs, set flag.
// RULE14: Power-good rise sets power_good_flag, maskable, with live status.
// RULE15: Clearing short circuit flag lets an enabled core start again.
// RULE16: Reset_occurred_flag means registers now hold their defaults.
// RULE17: Load measurement done sets a maskable flag with no status.
// RULE18: Masked flags still record but do not drive irq low.
module pil_protect_irq #(
    parameter int SC_CYC = pil_pkg::SC_CYC_DEF
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Asynchronous event sources
    input  wire pil_pkg::pil_ana_t anaRaw,
    input  wire logic              uvloGlitch,
    input  wire logic              reset_pin_n,
    // Same-clock requests
    input  wire logic              swResetReq,
    input  wire logic              loadMeasDone,
    input  wire logic [3:0]        coreEnable,
    // Core control
    output logic      [3:0]        coreRunEn,
    // Open-drain irq_out_n pin
    input  wire logic              irqOutI,
    output logic                   irqOutO,
    output logic                   irqOutOe
);
    localparam int W  = pil_pkg::CNT_W;
    localparam int NC = pil_pkg::NCORE;
    localparam logic [W-1:0] SC_T = W'(SC_CYC);
    localparam logic [W-1:0] SC_L = W'(SC_CYC - 1);

    // ----------------------------------------------------------------
    // Synchronisers and debounce
    // ----------------------------------------------------------------
    logic [15:0]    sync1Reg;
    logic [15:0]    sync2Reg;
    logic [3:0]     ilimS;
    logic [3:0]     fbLowS;
    logic [3:0]     pgS;
    logic           twS;
    logic           tsdS;
    logic           uvloS;
    logic           pinS;
    logic [9:0]     debIn;
    logic [9:0]     debOut;
    logic [3:0]     ilimDeb;
    logic [3:0]     pgDeb;
    logic           twDeb;
    logic           tsdDeb;
    logic [3:0]     lowDeb;
    logic [3:0]     pgDebD;

    // Two flops per asynchronous level before any logic sees it
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1Reg <= 16'h0000;
            sync2Reg <= 16'h0000;
        end else begin
            sync1Reg <= {uvloGlitch, reset_pin_n, anaRaw};
            sync2Reg <= sync1Reg;
        end
    end

    assign {uvloS, pinS, ilimS, fbLowS, pgS, twS, tsdS} = sync2Reg;
    assign debIn = {ilimS, pgS, twS, tsdS};
    assign {ilimDeb, pgDeb, twDeb, tsdDeb} = debOut;

    // Short filters for current limit, power-good and temperature
    for (genvar g = 0; g < 10; g++) begin : gShort
        pil_debounce #(.LEN(pil_pkg::DEB_CYC)) uDeb (
            .clk_sys  (clk_sys),
            .arst_n   (arst_n),
            .rawIn    (debIn[g]),
            .levelOut (debOut[g])
        );
    end

    // Long filter for overload on each feedback comparator
    for (genvar g = 0; g < NC; g++) begin : gLong
        pil_debounce #(.LEN(SC_CYC)) uDeb (
            .clk_sys  (clk_sys),
            .arst_n   (arst_n),
            .rawIn    (fbLowS[g]),
            .levelOut (lowDeb[g])
        );
    end

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    logic holdNow;
    logic holdDReg;
    logic rstEvt;
    logic softRst;

    // Pin low or supply glitch holds registers at default
    assign holdNow = ~pinS | uvloS;
    // Release of the hold is the start-up after a fault [RULE4]
    assign rstEvt  = swResetReq | (holdDReg & ~holdNow); // [RULE13]
    assign softRst = holdNow | swResetReq;

    // Starts at one so the first release after arst_n counts
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            holdDReg <= 1'b1;
            pgDebD   <= 4'h0;
        end else begin
            holdDReg <= holdNow;
            pgDebD   <= pgDeb;
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic [31:0] rdMux;
    logic        mapped;
    logic [31:0] wData;
    logic        wrAcc;
    logic [7:0]  topClr;
    logic [15:0] coreClr;
    logic [31:0] prdataReg;

    // Per-core and top flags, masks and core state
    logic [3:0]  ilimFlag;
    logic [3:0]  scFlag;
    logic [3:0]  pgFlag;
    logic        twFlag;
    logic        tsdFlag;
    logic        ldFlag;
    logic        rstFlag;
    logic [3:0]  ilimMask;
    logic [3:0]  pgMask;
    logic        twMask;
    logic        ldMask;
    logic        rstMask;
    logic [3:0]  coreRunReg;
    logic [3:0]  summary;

    assign summary = ilimFlag | scFlag | pgFlag;
    assign wData   = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
                               {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wrAcc   = psel & penable & pwrite & mapped;

    // Read mux; also tells which offsets exist
    always_comb begin
        rdMux  = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            pil_pkg::OFF_TOP_FLAG: begin
                rdMux[3:0]              = summary;
                rdMux[pil_pkg::TOP_TW]  = twFlag;
                rdMux[pil_pkg::TOP_TSD] = tsdFlag;
                rdMux[pil_pkg::TOP_LD]  = ldFlag;
                rdMux[pil_pkg::TOP_RST] = rstFlag;
            end
            pil_pkg::OFF_TOP_MASK: begin
                rdMux[pil_pkg::TOP_TW]  = twMask;
                rdMux[pil_pkg::TOP_LD]  = ldMask;
                rdMux[pil_pkg::TOP_RST] = rstMask;
            end
            pil_pkg::OFF_TOP_STAT: begin
                rdMux[pil_pkg::TOP_TW]  = twDeb; // [RULE11]
                rdMux[pil_pkg::TOP_TSD] = tsdDeb; // [RULE12]
            end
            pil_pkg::OFF_FLAG01, pil_pkg::OFF_FLAG23: begin
                // Short circuit flags live in separate pair words [RULE8]
                for (int i = 0; i < 2; i++) begin
                    int c;
                    c = (paddr == pil_pkg::OFF_FLAG23) ? i + 2 : i;
                    rdMux[4*i+pil_pkg::CB_ILIM] = ilimFlag[c];
                    rdMux[4*i+pil_pkg::CB_SC]   = scFlag[c];
                    rdMux[4*i+pil_pkg::CB_PG]   = pgFlag[c];
                end
            end
            pil_pkg::OFF_CORE_MASK: begin
                for (int i = 0; i < NC; i++) begin
                    rdMux[4*i+pil_pkg::CB_ILIM] = ilimMask[i];
                    rdMux[4*i+pil_pkg::CB_PG]   = pgMask[i];
                end
            end
            pil_pkg::OFF_CORE_STAT: begin
                // Live bits, no latching [RULE7] [RULE14] [RULE9]
                for (int i = 0; i < NC; i++) begin
                    rdMux[4*i+pil_pkg::CB_ILIM] = ilimDeb[i];
                    rdMux[4*i+pil_pkg::CB_PG]   = pgDeb[i];
                    rdMux[4*i+pil_pkg::CB_RUN]  = coreRunReg[i];
                end
            end
            default: mapped = 1'b0;
        endcase
    end

    // Write-one-to-clear strobes; pair words map to core nibbles [RULE10]
    always_comb begin
        topClr  = 8'h00;
        coreClr = 16'h0000;
        if (wrAcc && paddr == pil_pkg::OFF_TOP_FLAG) begin
            topClr = wData[7:0];
        end
        if (wrAcc && paddr == pil_pkg::OFF_FLAG01) begin
            coreClr[7:0] = wData[7:0];
        end
        if (wrAcc && paddr == pil_pkg::OFF_FLAG23) begin
            coreClr[15:8] = wData[7:0];
        end
    end

    // Read data is captured in the setup cycle, zero wait states
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prdataReg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdataReg <= pwrite ? 32'h0000_0000 : rdMux;
        end
    end

    assign prdata  = prdataReg;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ----------------------------------------------------------------
    // Masks
    // ----------------------------------------------------------------
    // Masks return to default on any device reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ilimMask <= pil_pkg::CORE_MASK_RST;
            pgMask   <= pil_pkg::CORE_MASK_RST;
            twMask   <= pil_pkg::TOP_MASK_RST;
            ldMask   <= pil_pkg::TOP_MASK_RST;
            rstMask  <= pil_pkg::TOP_MASK_RST;
        end else if (softRst) begin
            ilimMask <= pil_pkg::CORE_MASK_RST;
            pgMask   <= pil_pkg::CORE_MASK_RST;
            twMask   <= pil_pkg::TOP_MASK_RST;
            ldMask   <= pil_pkg::TOP_MASK_RST;
            rstMask  <= pil_pkg::TOP_MASK_RST;
        end else if (wrAcc && paddr == pil_pkg::OFF_TOP_MASK) begin
            twMask  <= wData[pil_pkg::TOP_TW];
            ldMask  <= wData[pil_pkg::TOP_LD];
            rstMask <= wData[pil_pkg::TOP_RST];
        end else if (wrAcc && paddr == pil_pkg::OFF_CORE_MASK) begin
            for (int i = 0; i < NC; i++) begin
                ilimMask[i] <= wData[4*i+pil_pkg::CB_ILIM];
                pgMask[i]   <= wData[4*i+pil_pkg::CB_PG];
            end
        end
    end

    // ----------------------------------------------------------------
    // Short circuit detection
    // ----------------------------------------------------------------
    logic [W-1:0] stTmr [NC];
    logic [3:0]   scEv;

    // Start-up window timer, saturates at the check point
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NC; i++) begin
                stTmr[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NC; i++) begin
                if (!coreRunReg[i]) begin
                    stTmr[i] <= '0;
                end else if (stTmr[i] != SC_T) begin
                    stTmr[i] <= stTmr[i] + 1'b1;
                end
            end
        end
    end

    // Below threshold at the 1 ms mark, or overload after it [RULE8]
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            scEv[i] = coreRunReg[i] &
                      ((stTmr[i] == SC_L && fbLowS[i]) |
                       (stTmr[i] == SC_T && lowDeb[i]));
        end
    end

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    // Set beats clear; level sets keep flags while condition lasts
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ilimFlag <= 4'h0;
            scFlag   <= 4'h0;
            pgFlag   <= 4'h0;
        end else if (softRst) begin
            ilimFlag <= 4'h0;
            scFlag   <= 4'h0;
            pgFlag   <= 4'h0;
        end else begin
            for (int i = 0; i < NC; i++) begin
                // Warning class: flag only [RULE1] [RULE5] [RULE6]
                ilimFlag[i] <= ilimDeb[i] |
                    (ilimFlag[i] & ~coreClr[4*i+pil_pkg::CB_ILIM]);
                // Protection class: flag and core off [RULE8] [RULE10]
                scFlag[i] <= scEv[i] |
                    (scFlag[i] & ~coreClr[4*i+pil_pkg::CB_SC]);
                // Edge set, so a plain clear sticks [RULE14]
                pgFlag[i] <= (pgDeb[i] & ~pgDebD[i]) |
                    (pgFlag[i] & ~coreClr[4*i+pil_pkg::CB_PG]);
            end
        end
    end

    // Top flags; reset flag set survives the register reset [RULE16]
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            twFlag  <= 1'b0;
            tsdFlag <= 1'b0;
            ldFlag  <= 1'b0;
            rstFlag <= 1'b0;
        end else begin
            rstFlag <= rstEvt |
                (~softRst & rstFlag & ~topClr[pil_pkg::TOP_RST]); // [RULE13]
            if (softRst) begin
                twFlag  <= 1'b0;
                tsdFlag <= 1'b0;
                ldFlag  <= 1'b0;
            end else begin
                twFlag  <= twDeb |
                    (twFlag & ~topClr[pil_pkg::TOP_TW]); // [RULE11]
                tsdFlag <= tsdDeb |
                    (tsdFlag & ~topClr[pil_pkg::TOP_TSD]); // [RULE12]
                ldFlag  <= loadMeasDone |
                    (ldFlag & ~topClr[pil_pkg::TOP_LD]); // [RULE17]
            end
        end
    end

    // ----------------------------------------------------------------
    // Core control and interrupt pin
    // ----------------------------------------------------------------
    logic pending;
    logic irqReg;
    logic tsdBlock;

    // Cores stay off while shutdown is hot or still pending
    assign tsdBlock = tsdDeb | tsdFlag;

    // Clearing scFlag re-arms the core if still enabled [RULE15]
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coreRunReg <= 4'h0;
        end else begin
            coreRunReg <= coreEnable & ~scFlag &
                          ~{4{tsdBlock | softRst}}; // [RULE9] [RULE12]
        end
    end

    // Masked flags are excluded; short and shutdown are unmaskable
    assign pending = |(ilimFlag & ~ilimMask) | (|scFlag) |
                     |(pgFlag & ~pgMask) | (twFlag & ~twMask) |
                     tsdFlag | (ldFlag & ~ldMask) |
                     (rstFlag & ~rstMask); // [RULE18] [RULE2]

    // Pin held low until every pending flag is gone [RULE3]
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqReg <= 1'b0;
        end else begin
            irqReg <= pending;
        end
    end

    assign coreRunEn = coreRunReg;
    assign irqOutO   = 1'b0;
    assign irqOutOe  = irqReg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_irq_asserts: assert property ( // [RULE2]
        @(posedge clk_sys) disable iff (!arst_n)
        pending |=> irqOutOe)
        else $error("irq not driven while a flag is pending");

    a_irq_release: assert property ( // [RULE3]
        @(posedge clk_sys) disable iff (!arst_n)
        $fell(pending) |=> !irqOutOe ##0 $past(irqOutOe))
        else $error("irq not released after last flag cleared");

    a_masked_quiet: assert property ( // [RULE18]
        @(posedge clk_sys) disable iff (!arst_n)
        (twFlag && twMask && !pending)[*2] |-> !irqOutOe)
        else $error("masked flag drove the irq pin");

    a_ilim_sticky: assert property ( // [RULE6]
        @(posedge clk_sys) disable iff (!arst_n)
        (!softRst && ilimDeb[0]) |=> ilimFlag[0])
        else $error("current limit flag lost while active");

    a_sc_core_off: assert property ( // [RULE9]
        @(posedge clk_sys) disable iff (!arst_n)
        scEv[0] |=> scFlag[0] ##1 !coreRunEn[0])
        else $error("core kept running after short circuit");

    a_sc_startup: assert property ( // [RULE8]
        @(posedge clk_sys) disable iff (!arst_n)
        (coreRunReg[0] && stTmr[0] == SC_L && fbLowS[0] && !softRst)
        |=> scFlag[0])
        else $error("start-up short not flagged at 1 ms");

    a_tsd_all_off: assert property ( // [RULE12]
        @(posedge clk_sys) disable iff (!arst_n)
        tsdDeb |=> coreRunEn == 4'h0 && tsdFlag)
        else $error("cores running during thermal shutdown");

    a_tw_hold: assert property ( // [RULE11]
        @(posedge clk_sys) disable iff (!arst_n)
        (twDeb && !softRst) |=> twFlag)
        else $error("thermal warning flag cleared while hot");

    a_reset_flag: assert property ( // [RULE13]
        @(posedge clk_sys) disable iff (!arst_n)
        rstEvt |=> rstFlag && ilimMask == pil_pkg::CORE_MASK_RST)
        else $error("reset event did not set flag or defaults");

    a_pg_set: assert property ( // [RULE14]
        @(posedge clk_sys) disable iff (!arst_n)
        (!softRst && $rose(pgDeb[1])) |=> pgFlag[1])
        else $error("power-good rise not flagged");

    a_load_set: assert property ( // [RULE17]
        @(posedge clk_sys) disable iff (!arst_n)
        (!softRst && loadMeasDone) |=> ldFlag)
        else $error("load measurement flag not set");

    a_retry_start: assert property ( // [RULE15]
        @(posedge clk_sys) disable iff (!arst_n)
        (!scFlag[3] && coreEnable[3] && !tsdBlock && !softRst)
        |=> coreRunEn[3])
        else $error("enabled core did not restart");
endmodule
`default_nettype wire

// *** verification/pil_host_model.sv ***
// Host side of the interrupt line: open-drain wire with a pull-up.
// Assumes the block pulls the line only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module pil_host_model (
    // Pin drive from the block
    input  wire logic irqOutO,
    input  wire logic irqOutOe,
    // Level the host sees
    output logic      irqLine
);
    // ----------------------------------------------------------
    // Line resolution
    // ----------------------------------------------------------
    // Pull-up wins when released, never a stale low
    assign irqLine = irqOutOe ? irqOutO : 1'b1;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Bench for the protection interrupt logic, APB host tasks and scenarios.
// Assumes pil_pkg, pil_protect_irq and pil_host_model compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin \
    errorCnt++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic              clk_sys = 0, arst_n = 0, psel = 0, penable = 0;
    logic              pwrite = 0, pready, pslverr, err, irqOutO;
    logic              irqOutOe, irqLine, uvloGlitch = 0;
    logic              reset_pin_n = 1, swResetReq = 0, loadMeasDone = 0;
    logic [11:0]       paddr = '0;
    logic [31:0]       pwdata = '0, prdata, rd;
    logic [3:0]        coreEnable = '0, coreRunEn;
    pil_pkg::pil_ana_t anaRaw = '0;
    int                errorCnt = 0, testsRun = 0;

    // Short window keeps the start-up check fast
    pil_protect_irq #(.SC_CYC(20)) u_pil_protect_irq (.clk_sys, .arst_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
        .pready, .pslverr, .anaRaw, .uvloGlitch, .reset_pin_n, .swResetReq,
        .loadMeasDone, .coreEnable, .coreRunEn, .irqOutI(irqLine),
        .irqOutO, .irqOutOe);
    pil_host_model u_pil_host_model (.irqOutO, .irqOutOe, .irqLine);

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic reportAndStop;
        if (errorCnt == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_start_flag;
        cyc(8);
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("rstflag", 1'b1, rd[7])
        `CHK("irq", 1'b0, irqLine)
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h80);
        cyc(3);
        `CHK("irq", 1'b1, irqLine)
        apb(1, 12'hffc, 32'h1);
        `CHK("slverr", 1'b1, err)
    endtask
    task automatic t_masked_load;
        apb(1, pil_pkg::OFF_TOP_MASK, 32'h40);
        loadMeasDone <= 1;
        cyc(1);
        loadMeasDone <= 0;
        cyc(3);
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("ldflag", 1'b1, rd[6])
        `CHK("irqoe", 1'b0, irqOutOe)
        apb(1, pil_pkg::OFF_TOP_MASK, 0);
        cyc(3);
        `CHK("irq", 1'b0, irqLine)
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h40);
        cyc(3);
        `CHK("irq", 1'b1, irqLine)
    endtask
    // Current limit, power-good and warning share one debounce wait
    task automatic t_hot;
        apb(1, pil_pkg::OFF_TOP_MASK, 32'h10);
        anaRaw.ilim[0] <= 1;
        anaRaw.pg[1] <= 1;
        anaRaw.tWarn <= 1;
        cyc(2010);
        apb(0, pil_pkg::OFF_CORE_STAT, 0);
        `CHK("ilimst", 2'b11, {rd[6], rd[0]})
        apb(1, pil_pkg::OFF_FLAG01, 32'h41);
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h10);
        apb(0, pil_pkg::OFF_FLAG01, 0);
        `CHK("ilimfl", 2'b01, {rd[6], rd[0]})
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("twfl", 2'b11, {rd[4], rd[0]})
        anaRaw <= '0;
        cyc(2010);
        apb(1, pil_pkg::OFF_FLAG01, 32'h01);
        // Only the masked warning is left: flag kept, line released
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("twmasked", 2'b11, {irqLine, rd[4]})
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h10);
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("top", 8'h00, rd[7:0])
    endtask
    task automatic t_short;
        anaRaw.fbLow[0] <= 1;
        coreEnable <= 4'h1;
        cyc(40);
        apb(0, pil_pkg::OFF_FLAG01, 0);
        `CHK("scfl", 1'b1, rd[1])
        apb(0, pil_pkg::OFF_CORE_STAT, 0);
        `CHK("run", 1'b0, rd[3])
        `CHK("irq", 1'b0, irqLine)
        anaRaw.fbLow[0] <= 0;
        apb(1, pil_pkg::OFF_FLAG01, 32'h2);
        cyc(40);
        `CHK("runen", 4'h1, coreRunEn)
        coreEnable <= 4'hf;
        anaRaw.tSd <= 1;
        cyc(2010);
        `CHK("tsdoff", 4'h0, coreRunEn)
        anaRaw.tSd <= 0;
        cyc(2010);
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h20);
        cyc(5);
        `CHK("tsdon", 4'hf, coreRunEn)
    endtask
    task automatic t_sw_reset;
        apb(1, pil_pkg::OFF_TOP_MASK, 32'h80);
        swResetReq <= 1;
        cyc(1);
        swResetReq <= 0;
        cyc(6);
        apb(0, pil_pkg::OFF_TOP_MASK, 0);
        `CHK("mask", 32'h0, rd)
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("rstflag", 1'b1, rd[7])
        // Reset pin pulse: cores off while held, flag on release
        apb(1, pil_pkg::OFF_TOP_FLAG, 32'h80);
        reset_pin_n <= 0;
        cyc(4);
        `CHK("pinoff", 4'h0, coreRunEn)
        reset_pin_n <= 1;
        cyc(6);
        apb(0, pil_pkg::OFF_TOP_FLAG, 0);
        `CHK("pinflag", 1'b1, rd[7])
    endtask

    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        cyc(12);
        arst_n <= 1;
        t_start_flag();
        t_masked_load();
        t_hot();
        t_short();
        t_sw_reset();
        reportAndStop();
    end
    initial begin
        cyc(30000);
        errorCnt++;
        reportAndStop();
    end
endmodule
`default_nettype wire
